// [radio_gpio_pin_config.sv]
/*
  General-pin configuration and direct I/O for the radio: the third pin's
  configuration register, the shared port register, the third pin's output
  mux and the interrupt-on-data-out option.
  Assumes the first two pins' function codes, the controller clock level,
  the timer flag, the interrupt request and the serial data out come from
  other logic on sys_clk; pin levels and chip select come from pins.
*/
`timescale 1ns/10ps
module radio_gpio_pin_config (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic [4:0] pin0FunctionSelect,
  input wire logic [4:0] pin1FunctionSelect,
  input wire logic pin0In,
  input wire logic pin1In,
  input wire logic pin2In,
  output logic pin0DirectOut,
  output logic pin0DirectOutEn,
  output logic pin1DirectOut,
  output logic pin1DirectOutEn,
  output logic pin2Out,
  output logic pin2OutEn,
  output logic pin2PullupEn,
  output logic [1:0] pin2DriveStrength,
  input wire logic mcuClockLevel,
  input wire logic wakeupTimerExpired,
  input wire logic interruptRequest_n,
  input wire logic chipSelect_n,
  input wire logic spiDataOut,
  input wire logic spiDataOutEn,
  output logic sdoOut,
  output logic sdoOutEn
);
  logic [7:0] pin2Config_reg;
  logic [2:0] directValue_reg;
  logic itsdo_reg;
  logic [7:0] readData_reg;
  logic pin0DirectOut_reg;
  logic pin0DirectOutEn_reg;
  logic pin1DirectOut_reg;
  logic pin1DirectOutEn_reg;
  logic pin2Out_reg;
  logic pin2OutEn_reg;
  logic pin2PullupEn_reg;
  logic [1:0] pin2DriveStrength_reg;
  logic sdoOut_reg;
  logic sdoOutEn_reg;

  logic [7:0] readData_next;
  logic pin2Out_next;
  logic pin2OutEn_next;
  logic pin2IsDigitalIn;
  logic [4:0] pin2Function;
  logic [4:0] pinFunction [radio_gpio_pkg::PIN_COUNT];
  logic [2:0] pinRaw;
  logic [2:0] pinLevel;
  logic [2:0] pinRise;
  logic [2:0] pinFall;
  logic [2:0] irqStatus;
  logic [2:0] isDirectIn;
  logic [2:0] isDirectOut;
  logic [2:0] directRead;
  logic statusClear;
  logic chipSelectLevel;
  logic chipSelectUnused0;
  logic chipSelectUnused1;
  radio_gpio_pkg::irq_mode_e irqMode [radio_gpio_pkg::PIN_COUNT];

  assign pin2Function = pin2Config_reg[radio_gpio_pkg::FUNC_MSB:radio_gpio_pkg::FUNC_LSB];
  assign pinFunction[0] = pin0FunctionSelect;
  assign pinFunction[1] = pin1FunctionSelect;
  assign pinFunction[2] = pin2Function;
  assign pinRaw = {pin2In, pin1In, pin0In};

  // Reading the port register clears the interrupt status bits
  assign statusClear = regRead && (regAddr == radio_gpio_pkg::IO_PORT_ADDR);

  // Third pin configuration register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin2Config_reg <= radio_gpio_pkg::PIN2_CONFIG_RESET;
    end else if (regWrite && (regAddr == radio_gpio_pkg::PIN2_CONFIG_ADDR)) begin
      pin2Config_reg <= regWriteData;
    end
  end

  // Writable part of the port register; upper bits are read-only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      directValue_reg <= radio_gpio_pkg::DIRECT_RESET;
      itsdo_reg <= radio_gpio_pkg::ITSDO_RESET;
    end else if (regWrite && (regAddr == radio_gpio_pkg::IO_PORT_ADDR)) begin
      directValue_reg <= regWriteData[radio_gpio_pkg::DIRECT_LSB +: 3];
      itsdo_reg <= regWriteData[radio_gpio_pkg::ITSDO_BIT];
    end
  end

  // Per-pin mode decode, synchroniser and interrupt status
  genvar i;
  generate
    for (i = 0; i < radio_gpio_pkg::PIN_COUNT; i++) begin : g_pin
      always_comb begin
        isDirectIn[i] = (pinFunction[i] == radio_gpio_pkg::FN_DIRECT_IN);
        isDirectOut[i] = (pinFunction[i] == radio_gpio_pkg::FN_DIRECT_OUT);
        if (pinFunction[i] == radio_gpio_pkg::FN_IRQ_FALL) begin
          irqMode[i] = radio_gpio_pkg::IRQ_FALL;
        end else if (pinFunction[i] == radio_gpio_pkg::FN_IRQ_RISE) begin
          irqMode[i] = radio_gpio_pkg::IRQ_RISE;
        end else if (pinFunction[i] == radio_gpio_pkg::FN_IRQ_CHANGE) begin
          irqMode[i] = radio_gpio_pkg::IRQ_CHANGE;
        end else begin
          irqMode[i] = radio_gpio_pkg::IRQ_OFF;
        end
        directRead[i] = isDirectIn[i] ? pinLevel[i] : directValue_reg[i];
      end

      pin_input_sync u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pinIn(pinRaw[i]),
        .level(pinLevel[i]),
        .rise(pinRise[i]),
        .fall(pinFall[i])
      );

      ext_irq_detect u_irq (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .mode(irqMode[i]),
        .rise(pinRise[i]),
        .fall(pinFall[i]),
        .clearPulse(statusClear),
        .status(irqStatus[i])
      );
    end
  endgenerate

  // Chip select passes the same three-stage filter
  pin_input_sync u_cs_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pinIn(chipSelect_n),
    .level(chipSelectLevel),
    .rise(chipSelectUnused0),
    .fall(chipSelectUnused1)
  );

  // Read data mux
  always_comb begin
    readData_next = 8'h00;
    if (regAddr == radio_gpio_pkg::PIN2_CONFIG_ADDR) begin
      readData_next = pin2Config_reg;
    end else if (regAddr == radio_gpio_pkg::IO_PORT_ADDR) begin
      readData_next[radio_gpio_pkg::RESERVED_BIT] = 1'b0;
      readData_next[radio_gpio_pkg::STATUS_LSB +: 3] = irqStatus;
      readData_next[radio_gpio_pkg::ITSDO_BIT] = itsdo_reg;
      readData_next[radio_gpio_pkg::DIRECT_LSB +: 3] = directRead;
    end
  end

  // Read data stands for the one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      readData_reg <= 8'h00;
    end else if (regRead) begin
      readData_reg <= readData_next;
    end else begin
      readData_reg <= 8'h00;
    end
  end

  // Third pin function mux
  always_comb begin
    pin2Out_next = 1'b0;
    pin2OutEn_next = 1'b1;
    pin2IsDigitalIn = 1'b0;
    if (pin2Function == radio_gpio_pkg::FN_MCU_CLOCK) begin
      pin2Out_next = mcuClockLevel;
    end else if (pin2Function == radio_gpio_pkg::FN_WAKEUP) begin
      pin2Out_next = wakeupTimerExpired;
    end else if (pin2Function == radio_gpio_pkg::FN_DIRECT_OUT) begin
      pin2Out_next = directValue_reg[2];
    end else if (pin2Function == radio_gpio_pkg::FN_TIE_HIGH) begin
      pin2Out_next = 1'b1;
    end else if (isDirectIn[2] || (irqMode[2] != radio_gpio_pkg::IRQ_OFF)
                 || (pin2Function == radio_gpio_pkg::FN_TX_DATA_IN)
                 || (pin2Function == radio_gpio_pkg::FN_RETRANSMIT_IN)) begin
      pin2OutEn_next = 1'b0;
      pin2IsDigitalIn = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin2Out_reg <= 1'b0;
      pin2OutEn_reg <= 1'b0;
      pin2PullupEn_reg <= 1'b0;
      pin2DriveStrength_reg <= 2'h0;
    end else begin
      pin2Out_reg <= pin2Out_next;
      pin2OutEn_reg <= pin2OutEn_next;
      pin2PullupEn_reg <= pin2IsDigitalIn
                          && pin2Config_reg[radio_gpio_pkg::PULLUP_BIT];
      pin2DriveStrength_reg <=
        pin2Config_reg[radio_gpio_pkg::DRIVE_MSB:radio_gpio_pkg::DRIVE_LSB];
    end
  end

  // Direct outputs for the first two pins, muxed onto the pins elsewhere
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin0DirectOut_reg <= 1'b0;
      pin0DirectOutEn_reg <= 1'b0;
      pin1DirectOut_reg <= 1'b0;
      pin1DirectOutEn_reg <= 1'b0;
    end else begin
      pin0DirectOut_reg <= directValue_reg[0];
      pin0DirectOutEn_reg <= isDirectOut[0];
      pin1DirectOut_reg <= directValue_reg[1];
      pin1DirectOutEn_reg <= isDirectOut[1];
    end
  end

  // Data out carries the interrupt request while the interface is idle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sdoOut_reg <= 1'b0;
      sdoOutEn_reg <= 1'b0;
    end else if (chipSelectLevel && itsdo_reg) begin
      sdoOut_reg <= interruptRequest_n;
      sdoOutEn_reg <= 1'b1;
    end else begin
      sdoOut_reg <= spiDataOut;
      sdoOutEn_reg <= spiDataOutEn && !chipSelectLevel;
    end
  end

  assign regReadData = readData_reg;
  assign pin0DirectOut = pin0DirectOut_reg;
  assign pin0DirectOutEn = pin0DirectOutEn_reg;
  assign pin1DirectOut = pin1DirectOut_reg;
  assign pin1DirectOutEn = pin1DirectOutEn_reg;
  assign pin2Out = pin2Out_reg;
  assign pin2OutEn = pin2OutEn_reg;
  assign pin2PullupEn = pin2PullupEn_reg;
  assign pin2DriveStrength = pin2DriveStrength_reg;
  assign sdoOut = sdoOut_reg;
  assign sdoOutEn = sdoOutEn_reg;
endmodule

// [radio_gpio_pkg.sv]
/*
  Constants for the general-pin configuration block: register offsets,
  field positions, reset values and pin function codes.
  Assumes a 7-bit register address and 8-bit register data.
*/
// Operation
// - Bits 4:0 of the third pin's configuration register select the function on that pin.
// - Code 00000 drives the controller clock out, code 00001 drives the timer-expired flag.
// - Bits 7:6 of that register set the pin's drive strength.
// - Bit 5 turns on the pull-up while the pin is a digital input.
// - The whole configuration register resets to zero.
// - Port bits 6, 5 and 4 show the interrupt status of the third, second and first pin.
// - With port bit 3 set and chip select high, the interrupt request goes out on data out.
// - Port bits 2, 1 and 0 drive the third, second and first pin when they are direct outputs.
// - Reading those bits returns the pin level when the pin is a direct input.
// - Codes 00100, 00101 and 00110 pick falling, rising and any-edge interrupt inputs.
// - Code 00011 is a direct input and code 01010 a direct output.
package radio_gpio_pkg;
  localparam int ADDR_WIDTH = 7;
  localparam int DATA_WIDTH = 8;
  localparam int PIN_COUNT = 3;
  localparam logic [6:0] PIN2_CONFIG_ADDR = 7'h0d;
  localparam logic [6:0] IO_PORT_ADDR = 7'h0e;

  localparam int FUNC_LSB = 0;
  localparam int FUNC_MSB = 4;
  localparam int PULLUP_BIT = 5;
  localparam int DRIVE_LSB = 6;
  localparam int DRIVE_MSB = 7;
  localparam int DIRECT_LSB = 0;
  localparam int ITSDO_BIT = 3;
  localparam int STATUS_LSB = 4;
  localparam int RESERVED_BIT = 7;

  localparam logic [7:0] PIN2_CONFIG_RESET = 8'h00;
  localparam logic [2:0] DIRECT_RESET = 3'h0;
  localparam logic ITSDO_RESET = 1'h0;

  localparam logic [4:0] FN_MCU_CLOCK = 5'h00;
  localparam logic [4:0] FN_WAKEUP = 5'h01;
  localparam logic [4:0] FN_DIRECT_IN = 5'h03;
  localparam logic [4:0] FN_IRQ_FALL = 5'h04;
  localparam logic [4:0] FN_IRQ_RISE = 5'h05;
  localparam logic [4:0] FN_IRQ_CHANGE = 5'h06;
  localparam logic [4:0] FN_DIRECT_OUT = 5'h0a;
  localparam logic [4:0] FN_TX_DATA_IN = 5'h10;
  localparam logic [4:0] FN_RETRANSMIT_IN = 5'h11;
  localparam logic [4:0] FN_TIE_HIGH = 5'h1d;

  typedef enum logic [1:0] {IRQ_OFF, IRQ_FALL, IRQ_RISE, IRQ_CHANGE} irq_mode_e;
endpackage

// [pin_input_sync.sv]
/*
  Three-stage synchroniser for one pin, with a filtered level and
  one-cycle rise and fall pulses.
  Assumes pinIn is asynchronous to sys_clk.
*/
`timescale 1ns/10ps
module pin_input_sync (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic stage1Reg;
  logic stage2Reg;
  logic stage3Reg;
  logic levelReg;
  logic riseReg;
  logic fallReg;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stage1Reg <= 1'b0;
      stage2Reg <= 1'b0;
      stage3Reg <= 1'b0;
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      levelReg <= 1'b0;
      riseReg <= 1'b0;
      fallReg <= 1'b0;
    end else begin
      riseReg <= (stage2Reg == stage3Reg) && stage3Reg && !levelReg;
      fallReg <= (stage2Reg == stage3Reg) && !stage3Reg && levelReg;
      if (stage2Reg == stage3Reg) begin
        levelReg <= stage3Reg;
      end
    end
  end

  assign level = levelReg;
  assign rise = riseReg;
  assign fall = fallReg;
endmodule

// [ext_irq_detect.sv]
/*
  Sticky external-interrupt status for one pin.
  Assumes rise and fall are one-cycle pulses on sys_clk.
*/
`timescale 1ns/10ps
module ext_irq_detect (
  input wire logic sys_clk,
  input wire logic reset_n,
  input radio_gpio_pkg::irq_mode_e mode,
  input wire logic rise,
  input wire logic fall,
  input wire logic clearPulse,
  output logic status
);
  logic statusReg;
  logic hit;

  always_comb begin
    unique case (mode)
      radio_gpio_pkg::IRQ_OFF: hit = 1'b0;
      radio_gpio_pkg::IRQ_FALL: hit = fall;
      radio_gpio_pkg::IRQ_RISE: hit = rise;
      radio_gpio_pkg::IRQ_CHANGE: hit = rise | fall;
    endcase
  end

  // Event in the clearing cycle keeps the bit set
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      statusReg <= 1'b0;
    end else if (hit) begin
      statusReg <= 1'b1;
    end else if (clearPulse) begin
      statusReg <= 1'b0;
    end
  end

  assign status = statusReg;
endmodule

// [radio_gpio_pin_config_asserts.sv]
/*
  Port checker for the general-pin configuration block.
  Assumes one clock, synchronous active-low reset; bound to every instance.
*/
`timescale 1ns/10ps
module radio_gpio_pin_config_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic [4:0] pin0FunctionSelect,
  input wire logic pin0DirectOutEn,
  input wire logic pin2OutEn,
  input wire logic pin2PullupEn,
  input wire logic [1:0] pin2DriveStrength,
  input wire logic interruptRequest_n,
  input wire logic chipSelect_n,
  input wire logic spiDataOut,
  input wire logic spiDataOutEn,
  input wire logic sdoOut,
  input wire logic sdoOutEn
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  reset_default_a: assert property (
    $rose(reset_n) |-> ##2 pin2OutEn && !pin2PullupEn && pin2DriveStrength == 2'b00)
    else $error("pin2 not at reset defaults");
  drive_follows_a: assert property (
    regWrite && regAddr == 7'h0d |-> ##2 pin2DriveStrength == $past(regWriteData[7:6], 2))
    else $error("drive strength does not follow write");
  pullup_input_a: assert property (pin2PullupEn |-> !pin2OutEn)
    else $error("pull-up on while pin2 drives");
  reserved_zero_a: assert property (
    $past(regRead) && $past(regAddr) == 7'h0e |-> !regReadData[7])
    else $error("reserved port bit reads one");
  direct_enable_a: assert property (
    pin0DirectOutEn == ($past(pin0FunctionSelect) == 5'h0a))
    else $error("pin0 enable does not match code");
  irq_status_mode_a: assert property (
    $past(regRead) && $past(regAddr) == 7'h0e && regReadData[4]
    |-> $past(pin0FunctionSelect) inside {5'h04, 5'h05, 5'h06})
    else $error("pin0 status without interrupt mode");
  irq_on_sdo_a: assert property (
    sdoOutEn && !$past(spiDataOutEn) |-> sdoOut == $past(interruptRequest_n))
    else $error("data out does not carry interrupt request");
  selected_spi_a: assert property (
    (!chipSelect_n)[*5] |=> sdoOutEn == $past(spiDataOutEn) && sdoOut == $past(spiDataOut))
    else $error("selected data out not from serial interface");
endmodule

bind radio_gpio_pin_config radio_gpio_pin_config_checker checker_i (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .regAddr(regAddr),
  .regWriteData(regWriteData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regReadData(regReadData),
  .pin0FunctionSelect(pin0FunctionSelect),
  .pin0DirectOutEn(pin0DirectOutEn),
  .pin2OutEn(pin2OutEn),
  .pin2PullupEn(pin2PullupEn),
  .pin2DriveStrength(pin2DriveStrength),
  .interruptRequest_n(interruptRequest_n),
  .chipSelect_n(chipSelect_n),
  .spiDataOut(spiDataOut),
  .spiDataOutEn(spiDataOutEn),
  .sdoOut(sdoOut),
  .sdoOutEn(sdoOutEn)
);

// [gpio_pin_partner.sv]
/*
  Far-side logic on the three general pins.
  Assumes device enables are high while the device drives a pin.
*/
`timescale 1ns/10ps
module gpio_pin_partner (
  input wire logic sys_clk,
  input wire logic [2:0] drvVal,
  input wire logic [2:0] drvEn,
  input wire logic [2:0] devOut,
  input wire logic [2:0] devEn,
  input wire logic pullUp2,
  output logic [2:0] pinLvl
);
  logic toggle = 1'b0;
  always @(posedge sys_clk) toggle <= ~toggle;
  // Device drive first, then ours, else pull-up or a moving level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinLvl[i] = devEn[i] ? devOut[i] : drvEn[i] ? drvVal[i] :
                  (i == 2 && pullUp2) ? 1'b1 : toggle;
    end
  end
endmodule

// [radio_gpio_pin_config_tb.sv]
/*
  Self-checking bench for the general-pin configuration block.
  Assumes the partner model resolves every pin level.
*/
`timescale 1ns/10ps
module radio_gpio_pin_config_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regReadData;
  logic [4:0] pin0FunctionSelect = 5'h00;
  logic [4:0] pin1FunctionSelect = 5'h00;
  logic pin0In, pin1In, pin2In;
  logic pin0DirectOut, pin0DirectOutEn, pin1DirectOut, pin1DirectOutEn;
  logic pin2Out, pin2OutEn, pin2PullupEn, sdoOut, sdoOutEn;
  logic [1:0] pin2DriveStrength;
  logic mcuClockLevel = 1'b0;
  logic wakeupTimerExpired = 1'b0;
  logic interruptRequest_n = 1'b1;
  logic chipSelect_n = 1'b1;
  logic spiDataOut = 1'b0;
  logic spiDataOutEn = 1'b0;
  logic [2:0] drvVal = 3'h0;
  logic [2:0] drvEn = 3'h0;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;

  gpio_pin_partner partner (
    .sys_clk(sys_clk),
    .drvVal(drvVal),
    .drvEn(drvEn),
    .devOut({pin2Out, pin1DirectOut, pin0DirectOut}),
    .devEn({pin2OutEn, pin1DirectOutEn, pin0DirectOutEn}),
    .pullUp2(pin2PullupEn),
    .pinLvl({pin2In, pin1In, pin0In})
  );
  radio_gpio_pin_config DUT (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .regAddr(regAddr),
    .regWriteData(regWriteData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regReadData(regReadData),
    .pin0FunctionSelect(pin0FunctionSelect),
    .pin1FunctionSelect(pin1FunctionSelect),
    .pin0In(pin0In),
    .pin1In(pin1In),
    .pin2In(pin2In),
    .pin0DirectOut(pin0DirectOut),
    .pin0DirectOutEn(pin0DirectOutEn),
    .pin1DirectOut(pin1DirectOut),
    .pin1DirectOutEn(pin1DirectOutEn),
    .pin2Out(pin2Out),
    .pin2OutEn(pin2OutEn),
    .pin2PullupEn(pin2PullupEn),
    .pin2DriveStrength(pin2DriveStrength),
    .mcuClockLevel(mcuClockLevel),
    .wakeupTimerExpired(wakeupTimerExpired),
    .interruptRequest_n(interruptRequest_n),
    .chipSelect_n(chipSelect_n),
    .spiDataOut(spiDataOut),
    .spiDataOutEn(spiDataOutEn),
    .sdoOut(sdoOut),
    .sdoOutEn(sdoOutEn)
  );

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input bit cmp = 1'b1);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    if (cmp) chk(regReadData, exp);
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    tick(3);
    chk(8'({pin2OutEn, pin2PullupEn, pin2DriveStrength}), 8'h08);
    rd(7'h0d, 8'h00);
    rd(7'h0e, 8'h00);
    rd(7'h0f, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) mcuClockLevel <= i[0];
      tick(3);
      chk(8'(pin2Out), 8'(i));
    end
    wr(7'h0d, 8'hc1);
    tick(3);
    chk(8'({pin2Out, pin2DriveStrength}), 8'h03);
    @(posedge sys_clk) wakeupTimerExpired <= 1'b1;
    tick(3);
    chk(8'(pin2Out), 8'h01);
    rd(7'h0d, 8'hc1);
    wr(7'h0e, 8'h08);
    wr(7'h0d, 8'h0a);
    @(posedge sys_clk);
    pin0FunctionSelect <= 5'h0a;
    pin1FunctionSelect <= 5'h0a;
    tick(3);
    chk(8'({pin1DirectOutEn, pin1DirectOut}), 8'h02);
    chk(8'({pin0DirectOutEn, pin0DirectOut, pin2OutEn, pin2Out}), 8'h0a);
    wr(7'h0e, 8'hff);
    tick(3);
    chk(8'({pin0DirectOutEn, pin0DirectOut, pin2OutEn, pin2Out}), 8'h0f);
    chk(8'({pin1DirectOutEn, pin1DirectOut}), 8'h03);
    rd(7'h0e, 8'h0f);
    wr(7'h0d, 8'h23);
    @(posedge sys_clk);
    pin0FunctionSelect <= 5'h00;
    pin1FunctionSelect <= 5'h00;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      drvEn <= 3'h4;
      drvVal <= {i[0], 2'b00};
      tick(6);
      rd(7'h0e, {5'h01, i[0], 2'b11});
    end
    chk(8'({pin2PullupEn, pin2OutEn}), 8'h02);
    @(posedge sys_clk);
    drvEn <= 3'h7;
    drvVal <= 3'h0;
    // Each interrupt code: clear, then one rise and one fall on all pins
    for (logic [4:0] c = 5'h04; c <= 5'h06; c++) begin
      @(posedge sys_clk);
      pin0FunctionSelect <= c;
      pin1FunctionSelect <= c;
      wr(7'h0d, {3'h0, c});
      tick(6);
      rd(7'h0e, 8'h00, 1'b0);
      @(posedge sys_clk) drvVal <= 3'h7;
      tick(8);
      rd(7'h0e, {1'b0, {3{c != 5'h04}}, 4'hf});
      @(posedge sys_clk) drvVal <= 3'h0;
      tick(8);
      rd(7'h0e, {1'b0, {3{c != 5'h05}}, 4'hf});
    end
    @(posedge sys_clk);
    pin0FunctionSelect <= 5'h00;
    pin1FunctionSelect <= 5'h00;
    // Idle chip select shows the request, selected shows serial data
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      interruptRequest_n <= i[0];
      spiDataOut <= i[0];
      chipSelect_n <= ~i[1];
      spiDataOutEn <= i[1];
      tick(6);
      chk(8'({sdoOutEn, sdoOut}), {7'h01, i[0]});
    end
    finish_test();
  end
endmodule
